// *** design/scp_card_if.sv ***
// Smart card serial interface: baud generator, half-duplex frame engine, bus registers
`timescale 1ns/1ns

module scp_card_if import scp_pkg::*; (
  input wire clk,
  input wire resetn,
  input scp_wb_req_t wb_req,
  output scp_wb_rsp_t wb_rsp,
  input wire data_pin_in,
  output scp_pins_t pins,
  output scp_irq_t irq
);

  scp_regs_t st;
  scp_regs_t next_st;
  logic [7:0] set_f;
  logic [7:0] clr_f;
  logic [7:0] rd;
  logic [8:0] rx_shift;
  logic [7:0] rx_char;
  logic tick;
  logic acc;
  logic wr;
  logic card_on;
  logic hold;
  logic odd;
  logic inv;
  logic msb;
  logic [3:0] shamt;
  logic [17:0] half_len;

  // Reorders a character between time order on the line and register order
  function automatic logic [7:0] scp_order(input logic [7:0] d, input logic msb_first);
    logic [7:0] r;
    r = d;
    for (int i = 0; i < 8; i++) begin
      if (msb_first) begin
        r[i] = d[7 - i];
      end
    end
    return r;
  endfunction

  assign card_on = st.card[SCP_CARD_ON];
  assign hold = st.mode[SCP_MODE_HOLD];
  assign odd = st.mode[SCP_MODE_ODD];
  assign inv = st.card[SCP_CARD_INV];
  assign msb = st.card[SCP_CARD_ORDER];
  // Half card-clock period is (N+1) * 4^n * 2^gear system clocks
  assign shamt = {1'b0, st.mode[SCP_MODE_PRE_HI:SCP_MODE_PRE_LO], 1'b0}
    + {2'b00, st.gear[1:0]};
  assign half_len = (18'(st.div) + 18'h00001) << shamt;
  assign rx_shift = {st.s2, st.rsh[8:1]};
  assign rx_char = scp_order(rx_shift[7:0] ^ {8{inv}}, msb);
  assign wb_rsp = st.rsp;
  assign pins = st.pins;
  assign irq = st.irq;

  always_comb begin
    next_st = st;
    set_f = '0;
    clr_f = '0;
    rd = '0;
    tick = 1'b0;
    acc = wb_req.cyc & wb_req.stb;
    wr = acc & st.rsp.ack & wb_req.we & wb_req.sel[0];
    next_st.s1 = data_pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;

    // Baud generator; a changed divisor cannot strand the counter past its limit
    if (!card_on || st.pre >= half_len - 18'h00001) begin
      next_st.pre = '0;
      if (card_on) begin
        next_st.ph = ~st.ph;
        tick = st.ph;
      end
    end else begin
      next_st.pre = st.pre + 18'h00001;
    end

    if (tick && st.state != SCP_IDLE) begin
      if (st.sub == SCP_ETU_TICKS - 9'h001) begin
        next_st.sub = '0;
        next_st.etu = st.etu + 4'h1;
      end else begin
        next_st.sub = st.sub + 9'h001;
      end
    end

    unique case (st.state)
      SCP_IDLE: begin
        next_st.sub = '0;
        next_st.etu = '0;
        next_st.retry = 1'b0;
        next_st.rx_bad = 1'b0;
        // Transmit wins when both are enabled; loop-back sees its own frame only on the pin
        if (card_on && st.ctrl[SCP_CTRL_TXON] && !st.flags[SCP_FLAG_TXE]) begin
          next_st.state = SCP_TX;
          next_st.frame = {^st.txb ^ odd, scp_order(st.txb, msb) ^ {8{inv}}, 1'b0};
          set_f[SCP_FLAG_TXE] = 1'b1;
          clr_f[SCP_FLAG_DONE] = 1'b1;
        end else if (card_on && st.ctrl[SCP_CTRL_RXON] && st.s3 && !st.s2) begin
          next_st.state = SCP_RX;
        end
      end
      SCP_TX: begin
        if (tick && st.sub == SCP_ETU_TICKS - 9'h001) begin
          // Card error signal is sampled at 11.0 etu, in the middle of its pulse
          if (st.etu == SCP_ERRSIG_ETU) begin
            if (!st.s2) begin
              set_f[SCP_FLAG_ERS] = 1'b1;
              next_st.retry = 1'b1;
            end else if (hold) begin
              set_f[SCP_FLAG_DONE] = 1'b1;
            end
          end
          if (st.etu == SCP_TX_END - 4'h1 && !st.retry) begin
            next_st.state = SCP_IDLE;
            if (!hold) begin
              set_f[SCP_FLAG_DONE] = 1'b1;
            end
          end
          if (st.etu == SCP_TX_RETRY - 4'h1 && st.retry) begin
            next_st.etu = '0;
            next_st.retry = 1'b0;
          end
        end
      end
      SCP_RX: begin
        if (tick && st.sub == SCP_SAMPLE_TICK) begin
          if (st.etu == '0) begin
            if (st.s2) begin
              next_st.state = SCP_IDLE; // Glitch, not a start bit
            end
          end else if (st.etu <= SCP_PARITY_ETU) begin
            next_st.rsh = rx_shift;
            if (st.etu == SCP_PARITY_ETU) begin
              if (st.flags[SCP_FLAG_RXF]) begin
                set_f[SCP_FLAG_OVR] = 1'b1;
              end else begin
                next_st.rxb = rx_char;
              end
              if ((^rx_char ^ odd) != rx_shift[8]) begin
                set_f[SCP_FLAG_PAR] = 1'b1;
                next_st.rx_bad = 1'b1;
              end else if (!st.flags[SCP_FLAG_RXF]) begin
                set_f[SCP_FLAG_RXF] = 1'b1;
              end
            end
          end else if (st.etu == SCP_ERRSIG_ETU && st.rx_bad) begin
            next_st.state = SCP_RX;
          end else begin
            next_st.state = SCP_IDLE;
          end
        end
      end
      default: begin
        next_st.state = SCP_IDLE;
      end
    endcase
    if (!card_on) begin
      next_st.state = SCP_IDLE;
    end

    // Wishbone slave: ack one cycle after the request, write at the ack edge
    next_st.rsp.ack = acc & ~st.rsp.ack;
    case (wb_req.adr)
      SCP_MODE_OFS: rd = st.mode;
      SCP_DIV_OFS: rd = st.div;
      SCP_CTRL_OFS: rd = st.ctrl;
      SCP_TXB_OFS: rd = st.txb;
      SCP_FLAG_OFS: rd = st.flags;
      SCP_RXB_OFS: rd = st.rxb;
      SCP_CARD_OFS: rd = st.card;
      SCP_GEAR_OFS: rd = st.gear;
      default: rd = '0;
    endcase
    next_st.rsp.dat = (acc && !st.rsp.ack) ? {24'h000000, rd} : '0;
    if (wr) begin
      case (wb_req.adr)
        SCP_MODE_OFS: next_st.mode = wb_req.dat[7:0];
        SCP_DIV_OFS: next_st.div = wb_req.dat[7:0];
        SCP_CTRL_OFS: next_st.ctrl = wb_req.dat[7:0];
        SCP_CARD_OFS: next_st.card = wb_req.dat[7:0];
        SCP_GEAR_OFS: next_st.gear = wb_req.dat[7:0] & SCP_GEAR_MASK;
        SCP_FLAG_OFS: clr_f = clr_f | (~wb_req.dat[7:0] & SCP_FLAG_W0C);
        SCP_TXB_OFS: begin
          next_st.txb = wb_req.dat[7:0];
          clr_f[SCP_FLAG_TXE] = 1'b1;
          clr_f[SCP_FLAG_DONE] = 1'b1;
        end
        default: next_st.txb = st.txb;
      endcase
    end
    if (acc && st.rsp.ack && !wb_req.we && wb_req.adr == SCP_RXB_OFS) begin
      clr_f[SCP_FLAG_RXF] = 1'b1;
    end
    // Hardware set wins over a software clear in the same cycle
    next_st.flags = (st.flags & ~clr_f) | set_f;

    // Open-drain data line: only ever pulled low, released means pulled-up high
    next_st.pins.data_out = 1'b0;
    next_st.pins.data_oe = card_on && (
      (next_st.state == SCP_TX && next_st.etu < SCP_FRAME_ETUS
        && !next_st.frame[next_st.etu])
      || (next_st.state == SCP_RX && next_st.rx_bad
        && ((next_st.etu == SCP_ERRSIG_ETU && next_st.sub >= SCP_SAMPLE_TICK)
          || next_st.etu == SCP_ERRSIG_END)));
    next_st.pins.clk_out = st.ctrl[SCP_CTRL_CLKON] ? next_st.ph
      : (hold & st.ctrl[SCP_CTRL_CLKLVL]);
    next_st.pins.clk_oe = card_on & (st.ctrl[SCP_CTRL_CLKON] | hold);
    next_st.irq.tx_empty_irq = st.flags[SCP_FLAG_DONE] & st.ctrl[SCP_CTRL_TXIRQ];
    next_st.irq.rx_full_irq = st.flags[SCP_FLAG_RXF] & st.ctrl[SCP_CTRL_RXIRQ];
    next_st.irq.comm_fault_irq = (st.flags[SCP_FLAG_OVR] | st.flags[SCP_FLAG_PAR]
      | st.flags[SCP_FLAG_ERS]) & st.ctrl[SCP_CTRL_RXIRQ];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.flags <= SCP_FLAG_RST;
    end else begin
      st <= next_st;
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_retry_end;
    st.retry ##1 !st.retry;
  endsequence

  sequence s_bus_req;
    wb_req.cyc && wb_req.stb && !st.rsp.ack;
  endsequence

  a_bus_ack_once: assert property (s_bus_req |=> st.rsp.ack ##1 !st.rsp.ack)
    else $error("bus ack not a single cycle after request");
  a_tx_start_done: assert property ($rose(st.state == SCP_TX)
    |-> !st.flags[SCP_FLAG_DONE] && st.flags[SCP_FLAG_TXE])
    else $error("done flag not cleared at transmit start");
  a_txirq_follows: assert property (st.flags[SCP_FLAG_DONE] && st.ctrl[SCP_CTRL_TXIRQ]
    |=> irq.tx_empty_irq)
    else $error("transmit empty request missing");
  a_rxirq_follows: assert property (st.flags[SCP_FLAG_RXF] && st.ctrl[SCP_CTRL_RXIRQ]
    |=> irq.rx_full_irq)
    else $error("receive full request missing");
  a_fault_irq_raise: assert property ((st.flags[SCP_FLAG_OVR] || st.flags[SCP_FLAG_PAR]
    || st.flags[SCP_FLAG_ERS]) && st.ctrl[SCP_CTRL_RXIRQ] |=> irq.comm_fault_irq)
    else $error("communication fault request missing");
  a_parity_no_full: assert property ($rose(st.flags[SCP_FLAG_PAR]) && st.state == SCP_RX
    |-> !$rose(st.flags[SCP_FLAG_RXF]) && st.rx_bad)
    else $error("bad character reported as complete");
  a_err_sig_drive: assert property (st.state == SCP_RX && st.rx_bad
    && st.etu == SCP_ERRSIG_END |-> pins.data_oe)
    else $error("error signal not driven");
  a_guard_time: assert property ($fell(st.state == SCP_TX) && card_on
    |-> st.etu == SCP_TX_END)
    else $error("transmit left before guard time");
  a_retry_restart: assert property (s_retry_end |-> st.state == SCP_TX && st.etu == '0
    || !card_on)
    else $error("retransmission did not restart frame");
  a_clk_toggle: assert property (card_on && st.pre >= half_len - 18'h00001
    |=> st.ph != $past(st.ph))
    else $error("card clock phase did not toggle at divider limit");

endmodule

// *** include/scp_pkg.sv ***
// Shared constants, carriers and state type of the smart card serial interface
package scp_pkg;

  // Register byte addresses on the bus (one 32-bit word each, data in bits 7:0)
  localparam logic [7:0] SCP_MODE_OFS = 8'h00; // serial_mode_reg
  localparam logic [7:0] SCP_DIV_OFS = 8'h04;  // rate_divisor_reg
  localparam logic [7:0] SCP_CTRL_OFS = 8'h08; // serial_ctrl_reg
  localparam logic [7:0] SCP_TXB_OFS = 8'h0C;  // tx_buffer
  localparam logic [7:0] SCP_FLAG_OFS = 8'h10; // serial_flag_reg
  localparam logic [7:0] SCP_RXB_OFS = 8'h14;  // rx_buffer
  localparam logic [7:0] SCP_CARD_OFS = 8'h18; // card_mode_reg
  localparam logic [7:0] SCP_GEAR_OFS = 8'h1C; // system clock divider gear

  // serial_mode_reg fields
  localparam int SCP_MODE_HOLD = 7; // clock_hold_variant
  localparam int SCP_MODE_ODD = 4;  // parity_odd_sel
  localparam int SCP_MODE_PRE_HI = 1; // prescale_sel_hi
  localparam int SCP_MODE_PRE_LO = 0; // prescale_sel_lo

  // serial_ctrl_reg fields
  localparam int SCP_CTRL_TXIRQ = 7; // tx_irq_on
  localparam int SCP_CTRL_RXIRQ = 6; // rx_irq_on
  localparam int SCP_CTRL_TXON = 5;  // tx_on
  localparam int SCP_CTRL_RXON = 4;  // rx_on
  localparam int SCP_CTRL_CLKLVL = 1; // clk_level_sel
  localparam int SCP_CTRL_CLKON = 0;  // clk_out_on

  // serial_flag_reg fields
  localparam int SCP_FLAG_TXE = 7;  // tx_empty_flag
  localparam int SCP_FLAG_RXF = 6;  // rx_full_flag
  localparam int SCP_FLAG_OVR = 5;  // overrun_flag
  localparam int SCP_FLAG_ERS = 4;  // tx_error_signal_flag
  localparam int SCP_FLAG_PAR = 3;  // parity_fail_flag
  localparam int SCP_FLAG_DONE = 2; // tx_done_flag

  // card_mode_reg fields
  localparam int SCP_CARD_ORDER = 3; // bit_order_sel
  localparam int SCP_CARD_INV = 2;   // data_invert_sel
  localparam int SCP_CARD_ON = 0;    // card_mode_on

  // Reset values and write masks
  localparam logic [7:0] SCP_REG_RST = 8'h00;
  localparam logic [7:0] SCP_FLAG_RST = 8'h84;
  localparam logic [7:0] SCP_FLAG_W0C = 8'hF8;
  localparam logic [7:0] SCP_GEAR_MASK = 8'h03;

  // Frame timing in base ticks (372 per elementary time unit) and in etu
  localparam logic [8:0] SCP_ETU_TICKS = 9'h174;
  localparam logic [8:0] SCP_SAMPLE_TICK = 9'h0BA;
  localparam logic [3:0] SCP_PARITY_ETU = 4'h9;
  localparam logic [3:0] SCP_FRAME_ETUS = 4'hA;
  localparam logic [3:0] SCP_ERRSIG_ETU = 4'hA;
  localparam logic [3:0] SCP_ERRSIG_END = 4'hB;
  localparam logic [3:0] SCP_TX_END = 4'hC;
  localparam logic [3:0] SCP_TX_RETRY = 4'hD;

  typedef enum logic [1:0] {SCP_IDLE, SCP_TX, SCP_RX} scp_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } scp_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } scp_wb_rsp_t;

  typedef struct packed {
    logic data_out;
    logic data_oe;
    logic clk_out;
    logic clk_oe;
  } scp_pins_t;

  typedef struct packed {
    logic tx_empty_irq;
    logic rx_full_irq;
    logic comm_fault_irq;
  } scp_irq_t;

  typedef struct packed {
    scp_state_t state;
    logic [17:0] pre;
    logic ph;
    logic [8:0] sub;
    logic [3:0] etu;
    logic [9:0] frame;
    logic [8:0] rsh;
    logic retry;
    logic rx_bad;
    logic s1;
    logic s2;
    logic s3;
    logic [7:0] mode;
    logic [7:0] div;
    logic [7:0] ctrl;
    logic [7:0] card;
    logic [7:0] gear;
    logic [7:0] txb;
    logic [7:0] rxb;
    logic [7:0] flags;
    scp_wb_rsp_t rsp;
    scp_pins_t pins;
    scp_irq_t irq;
  } scp_regs_t;

endpackage

// *** test/scp_card_model.sv ***
// Smart card model: sends and takes characters on the pulled-up data line
`timescale 1ns/1ns
module scp_card_model #(
  parameter int ETU = 744
) (
  input wire clk,
  input wire line,
  output logic pull_low
);
  initial pull_low = 1'b0;

  // Line level of the eight data bits; the mapping undoes itself
  function automatic logic [7:0] lvl(input logic [7:0] d, input logic inv);
    for (int i = 0; i < 8; i++) begin
      lvl[i] = inv ? ~d[7 - i] : d[i];
    end
  endfunction

  task automatic send(input logic [7:0] d, input logic inv, input logic bad, output logic err);
    logic [9:0] f;
    f = {^d ^ inv ^ bad, lvl(d, inv), 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) pull_low <= ~f[i];
      repeat (ETU - 1) @(posedge clk);
    end
    @(posedge clk) pull_low <= 1'b0;
    repeat (ETU - 1) @(posedge clk);
    err = ~line;
    // Guard time before anyone may start again
    repeat (ETU) @(posedge clk);
  endtask

  task automatic recv(input logic inv, input logic rej, output logic [7:0] d, output logic ok);
    logic [8:0] b;
    int n;
    n = 0;
    while (line !== 1'b0 && n < 4 * ETU) begin
      @(posedge clk);
      n++;
    end
    repeat (ETU / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (ETU) @(posedge clk);
      b[i] = line;
    end
    repeat (ETU) @(posedge clk);
    pull_low <= rej;
    repeat (ETU) @(posedge clk);
    pull_low <= 1'b0;
    d = lvl(b[7:0], inv);
    ok = (b[8] === (^d ^ inv));
  endtask
endmodule

// *** test/test_smart_card_serial_interface.sv ***
// Testbench for the smart card serial interface
`timescale 1ns/1ns
module test_smart_card_serial_interface import scp_pkg::*;;
  localparam int ETU = 744;
  logic clk;
  logic resetn;
  scp_wb_req_t req;
  scp_wb_rsp_t rsp;
  scp_pins_t pins;
  scp_irq_t irq;
  logic card_low;
  logic line;
  logic e;
  logic [7:0] v;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc_n = 0;

  // Open-drain line with pull-up
  assign line = ~(pins.data_oe | card_low);

  scp_card_if dut_u (
    .clk(clk),
    .resetn(resetn),
    .wb_req(req),
    .wb_rsp(rsp),
    .data_pin_in(line),
    .pins(pins),
    .irq(irq)
  );

  scp_card_model #(.ETU(ETU)) card_u (
    .clk(clk),
    .line(line),
    .pull_low(card_low)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 90000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    req <= '{1'b1, 1'b1, we, a, 4'hF, {24'h000000, d}};
    do @(posedge clk); while (rsp.ack !== 1'b1);
    q = rsp.dat[7:0];
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, exp});
  endtask

  // Counts card clock rises over ETU (744) system clocks at the given divisor, prescale and gear setting
  task automatic rate(input logic [7:0] dv, input logic [7:0] md, input logic [7:0] gr,
                      input logic [15:0] exp);
    logic p;
    int k;
    wr(SCP_DIV_OFS, dv);
    wr(SCP_MODE_OFS, md);
    wr(SCP_GEAR_OFS, gr);
    repeat (8) @(posedge clk);
    k = 0;
    p = pins.clk_out;
    repeat (ETU) begin
      @(posedge clk);
      if (pins.clk_out === 1'b1 && p === 1'b0)
        k++;
      p = pins.clk_out;
    end
    chk(k[15:0], exp);
  endtask

  task automatic setup(input logic [7:0] cm, input logic [7:0] md, input logic [7:0] ct);
    wr(SCP_CTRL_OFS, 8'h00);
    wr(SCP_FLAG_OFS, 8'hC7);
    wr(SCP_MODE_OFS, md);
    wr(SCP_GEAR_OFS, 8'h00);
    wr(SCP_CARD_OFS, cm);
    wr(SCP_CTRL_OFS, 8'h01);
    repeat (ETU) @(posedge clk);
    chk({15'h0000, pins.data_oe}, 16'h0000);
    wr(SCP_CTRL_OFS, ct);
    // Interrupt requests follow the enables one cycle after the write lands
    repeat (2) @(posedge clk);
  endtask

  initial begin
    resetn = 1'b0;
    req = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rc(SCP_FLAG_OFS, 8'h84);
    rc(SCP_MODE_OFS, 8'h00);
    rc(8'h20, 8'h00);
    wr(SCP_CTRL_OFS, 8'h01);
    // The baud generator only runs in card mode
    wr(SCP_CARD_OFS, 8'h01);
    rate(8'h00, 8'h00, 8'h00, 16'h0174);
    rate(8'h01, 8'h00, 8'h00, 16'h00BA);
    rate(8'h00, 8'h01, 8'h00, 16'h005D);
    rate(8'h00, 8'h00, 8'h01, 16'h00BA);
    setup(8'h01, 8'h00, 8'hE1);
    chk({15'h0000, irq.tx_empty_irq}, 16'h0001);
    wr(SCP_TXB_OFS, 8'h3B);
    rc(SCP_FLAG_OFS, 8'h80);
    card_u.recv(1'b0, 1'b0, v, e);
    chk({8'h00, v}, 16'h003B);
    chk({15'h0000, e}, 16'h0001);
    rc(SCP_FLAG_OFS, 8'h80);
    repeat (ETU) @(posedge clk);
    rc(SCP_FLAG_OFS, 8'h84);
    chk({15'h0000, irq.tx_empty_irq}, 16'h0001);
    wr(SCP_TXB_OFS, 8'h3C);
    card_u.recv(1'b0, 1'b1, v, e);
    rc(SCP_FLAG_OFS, 8'h90);
    chk({15'h0000, irq.comm_fault_irq}, 16'h0001);
    chk({15'h0000, irq.tx_empty_irq}, 16'h0000);
    card_u.recv(1'b0, 1'b0, v, e);
    chk({8'h00, v}, 16'h003C);
    wr(SCP_FLAG_OFS, 8'hEF);
    repeat (ETU) @(posedge clk);
    rc(SCP_FLAG_OFS, 8'h84);
    setup(8'h0D, 8'h90, 8'h21);
    wr(SCP_TXB_OFS, 8'h3F);
    card_u.recv(1'b1, 1'b0, v, e);
    chk({8'h00, v}, 16'h003F);
    chk({15'h0000, e}, 16'h0001);
    rc(SCP_FLAG_OFS, 8'h84);
    setup(8'h01, 8'h00, 8'h51);
    card_u.send(8'hA5, 1'b0, 1'b0, e);
    chk({15'h0000, e}, 16'h0000);
    rc(SCP_FLAG_OFS, 8'hC4);
    chk({15'h0000, irq.rx_full_irq}, 16'h0001);
    rc(SCP_RXB_OFS, 8'hA5);
    card_u.send(8'h5A, 1'b0, 1'b1, e);
    chk({15'h0000, e}, 16'h0001);
    rc(SCP_FLAG_OFS, 8'h8C);
    chk({15'h0000, irq.comm_fault_irq}, 16'h0001);
    rc(SCP_RXB_OFS, 8'h5A);
    summarize();
  end
endmodule
